// ===== core/pis_defines.svh
// Bit positions, the code width and sizes for the peripheral interrupt status
// block. Included by the package and the core; definitions only.
`ifndef PIS_DEFINES_SVH
`define PIS_DEFINES_SVH

`define PIS_WORD_W        32
`define PIS_CODE_W        5
`define PIS_NUM_TIMERS    5
`define PIS_NUM_DIO       21

`define PIS_SC_CLK_SW     31
`define PIS_SC_RND        30
`define PIS_SC_CMP1       29
`define PIS_SC_CMP0       28
`define PIS_SC_WK1        27
`define PIS_SC_WK0        26
`define PIS_SC_BO_IN      25
`define PIS_SC_BO_OUT     24
`define PIS_SC_PC1        23
`define PIS_SC_PC0        22

`define PIS_AP_OVER       4
`define PIS_AP_FULL       3
`define PIS_AP_HALF       2
`define PIS_AP_ACC        1
`define PIS_AP_SAMP       0

`define PIS_TM_RISE       1
`define PIS_TM_PER        0
`define PIS_TICK_BIT      0
`define PIS_IR_BIT        0

`define PIS_SM_NOACK      7
`define PIS_SM_BUSY       6
`define PIS_SM_ARB        5
`define PIS_SM_BADCMD     2
`define PIS_SM_TIP        1
`define PIS_SM_IRQ        0

`define PIS_SS_ERR        4
`define PIS_SS_LAST       3
`define PIS_SS_RXW        2
`define PIS_SS_TAKEN      1
`define PIS_SS_NEED       0

`define PIS_ZERO_WORD     32'h0000_0000

`endif

// ===== core/pis_pkg.sv
// Types for the peripheral interrupt status block.
// Assumes pis_defines.svh is on the include path.
`include "pis_defines.svh"

package pis_pkg;

    // Source codes in the order peripherals are listed; codes not driven
    // here (serial ports, SPI master and slave, flash, cipher) are kept so numbering is stable.
    typedef enum logic [`PIS_CODE_W-1:0] {
        PIS_SRC_SYSCTRL,
        PIS_SRC_ANALOGUE,
        PIS_SRC_UART0,
        PIS_SRC_UART1,
        PIS_SRC_TIMER0,
        PIS_SRC_TIMER1,
        PIS_SRC_TIMER2,
        PIS_SRC_TIMER3,
        PIS_SRC_TIMER4,
        PIS_SRC_TICK,
        PIS_SRC_TWO_WIRE,
        PIS_SRC_SPIM,
        PIS_SRC_SPIS,
        PIS_SRC_FLASH,
        PIS_SRC_INFRARED,
        PIS_SRC_CIPHER
    } pis_src_t;

    typedef enum logic {
        PIS_ST_IDLE,
        PIS_ST_REPORT
    } pis_state_t;

    typedef struct packed {
        pis_state_t                       st;
        logic [`PIS_WORD_W-1:0]           sc;
        logic [`PIS_WORD_W-1:0]           ap;
        logic [`PIS_NUM_TIMERS-1:0][1:0]  tm;
        logic                             tick;
        logic                             ir;
        logic [`PIS_WORD_W-1:0]           sm;
        logic [`PIS_WORD_W-1:0]           ss;
        logic                             busy;
        logic                             irq;
        pis_src_t                         code;
        logic [`PIS_WORD_W-1:0]           word;
    } pis_regs_t;

endpackage

// ===== core/pis_core.sv
// Peripheral interrupt status: collects one-cycle cause pulses from the
// peripherals, holds them sticky, and presents one source code plus its
// cause word to the processor until it acknowledges.
// Assumes every event input is a one-cycle pulse on mclk from logic on the
// same clock, and the processor pulses ack once per presented source.
// Assumes dio_event is no wider than the 21 digital lines, so it stays
// clear of bit 21 and of the wake timer and pulse counter bits above it.
`timescale 1ns/1ps
`include "pis_defines.svh"

module pis_core
    import pis_pkg::*;
#(
    parameter int NUM_TIMERS = `PIS_NUM_TIMERS,
    parameter int NUM_DIO    = `PIS_NUM_DIO
) (
    // Clock and synchronous reset
    input  wire logic                        mclk,
    input  wire logic                        rst,

    // System controller causes
    input  wire logic                        clock_switch_event,
    input  wire logic                        random_value_ready,
    input  wire logic                        comparator_one_event,
    input  wire logic                        comparator_zero_event,
    input  wire logic                        wake_timer_one_event,
    input  wire logic                        wake_timer_zero_event,
    input  wire logic                        brownout_entered,
    input  wire logic                        brownout_exited,
    input  wire logic                        pulse_count_one_match,
    input  wire logic                        pulse_count_zero_match,
    input  wire logic [NUM_DIO-1:0]          dio_event,

    // Analogue causes
    input  wire logic                        adc_dma_overflow,
    input  wire logic                        adc_dma_full,
    input  wire logic                        adc_dma_half_full,
    input  wire logic                        adc_accumulate_mode,
    input  wire logic                        adc_accumulate_done,
    input  wire logic                        adc_sample_done,

    // General timers: output levels and their edge enables
    input  wire logic [NUM_TIMERS-1:0]       timer_output,
    input  wire logic [NUM_TIMERS-1:0]       timer_rise_irq_en,
    input  wire logic [NUM_TIMERS-1:0]       timer_period_irq_en,

    // Tick timer and infrared transmitter
    input  wire logic                        tick_event,
    input  wire logic                        infrared_send_done,

    // Two-wire master
    input  wire logic                        two_wire_no_ack,
    input  wire logic                        two_wire_start_seen,
    input  wire logic                        two_wire_stop_seen,
    input  wire logic                        two_wire_arb_lost,
    input  wire logic                        two_wire_bad_command,
    input  wire logic                        two_wire_transfer_active,
    input  wire logic                        two_wire_byte_done,

    // Two-wire slave
    input  wire logic                        two_wire_slave_protocol_error,
    input  wire logic                        two_wire_slave_burst_end,
    input  wire logic                        two_wire_slave_rx_waiting,
    input  wire logic                        two_wire_slave_tx_taken,
    input  wire logic                        two_wire_slave_tx_needed,

    // Processor side
    input  wire logic                        ack,
    output logic                             irq_valid,
    output logic [`PIS_CODE_W-1:0]           source_peripheral_code,
    output logic [`PIS_WORD_W-1:0]           cause_word,
    output logic                             two_wire_bus_active
);

    pis_regs_t               q_r;
    pis_regs_t               d_nxt;
    pis_src_t                pick_code;
    logic [`PIS_WORD_W-1:0]  pick_word;
    // Timer output of the previous cycle, for edge detection
    logic [NUM_TIMERS-1:0]   tout_d_r;
    logic [NUM_TIMERS-1:0]   t_rise;
    logic [NUM_TIMERS-1:0]   t_fall;
    // Per-cycle cause words, before they are made sticky
    logic [`PIS_WORD_W-1:0]  sc_ev;
    logic [`PIS_WORD_W-1:0]  ap_ev;
    logic [`PIS_WORD_W-1:0]  sm_ev;
    logic [`PIS_WORD_W-1:0]  ss_ev;

    // Edge detect on timer outputs; gated by the per-timer enables
    // Rising edge feeds bit 1, falling edge (period end) feeds bit 0
    genvar g;
    generate
        for (g = 0; g < NUM_TIMERS; g++) begin : g_tm
            assign t_rise[g] = timer_output[g] & ~tout_d_r[g]
                             & timer_rise_irq_en[g];
            assign t_fall[g] = ~timer_output[g] & tout_d_r[g]
                             & timer_period_irq_en[g];
        end
    endgenerate

    // Reset value low: a timer output already high at reset release
    // reads as a rising edge, so timers are expected to start low.
    always_ff @(posedge mclk) begin
        if (rst) begin
            tout_d_r <= '0;
        end else begin
            tout_d_r <= timer_output;
        end
    end

    always_comb begin
        // System controller word
        sc_ev = `PIS_ZERO_WORD;
        sc_ev[`PIS_SC_CLK_SW] = clock_switch_event;
        sc_ev[`PIS_SC_RND]    = random_value_ready;
        sc_ev[`PIS_SC_CMP1]   = comparator_one_event;
        sc_ev[`PIS_SC_CMP0]   = comparator_zero_event;
        sc_ev[`PIS_SC_WK1]    = wake_timer_one_event;
        sc_ev[`PIS_SC_WK0]    = wake_timer_zero_event;
        sc_ev[`PIS_SC_BO_IN]  = brownout_entered;
        sc_ev[`PIS_SC_BO_OUT] = brownout_exited;
        sc_ev[`PIS_SC_PC1]    = pulse_count_one_match;
        sc_ev[`PIS_SC_PC0]    = pulse_count_zero_match;
        sc_ev[NUM_DIO-1:0]    = dio_event;

        // Analogue word; accumulation done only counts in that mode
        ap_ev = `PIS_ZERO_WORD;
        ap_ev[`PIS_AP_OVER] = adc_dma_overflow;
        ap_ev[`PIS_AP_FULL] = adc_dma_full;
        ap_ev[`PIS_AP_HALF] = adc_dma_half_full;
        ap_ev[`PIS_AP_ACC]  = adc_accumulate_done
                            & adc_accumulate_mode;
        ap_ev[`PIS_AP_SAMP] = adc_sample_done;

        // Two-wire master; bus-active and transfer-active are added live
        sm_ev = `PIS_ZERO_WORD;
        sm_ev[`PIS_SM_NOACK]  = two_wire_no_ack;
        sm_ev[`PIS_SM_ARB]    = two_wire_arb_lost;
        sm_ev[`PIS_SM_BADCMD] = two_wire_bad_command;
        sm_ev[`PIS_SM_IRQ]    = two_wire_arb_lost
                              | two_wire_byte_done;

        // Two-wire slave
        ss_ev = `PIS_ZERO_WORD;
        ss_ev[`PIS_SS_ERR]   = two_wire_slave_protocol_error;
        ss_ev[`PIS_SS_LAST]  = two_wire_slave_burst_end;
        ss_ev[`PIS_SS_RXW]   = two_wire_slave_rx_waiting;
        ss_ev[`PIS_SS_TAKEN] = two_wire_slave_tx_taken;
        ss_ev[`PIS_SS_NEED]  = two_wire_slave_tx_needed;
    end

    // Timing: an event sampled at edge N is sticky after N and presented
    // after N+1 when nothing else is pending. The presented source stands
    // until ack; ack drops irq_valid after that edge and the next pending
    // source can appear one edge later.
    // Priority: system, analogue, timers, tick, two-wire, infrared.
    // Two-wire master and slave share one code; their words are ORed.
    // Clearing is per source on ack and wipes every sticky bit of that
    // source, including causes that arrived after the word was latched;
    // a cause pulsed in the ack cycle itself is kept (set wins).
    // Limitation: tick and infrared have one bit each, so repeats while
    // presented merge into one report.

    always_comb begin
        d_nxt = q_r;

        // Bus-active level: a START in the same cycle as STOP wins
        if (two_wire_start_seen) begin
            d_nxt.busy = 1'b1;
        end else if (two_wire_stop_seen) begin
            d_nxt.busy = 1'b0;
        end

        // Acknowledge clears the presented source; events of the same
        // cycle are ORed in after the clear so none is lost.
        if (q_r.st == PIS_ST_REPORT && ack) begin
            d_nxt.st = PIS_ST_IDLE;
            d_nxt.irq = 1'b0;
            case (q_r.code)
                PIS_SRC_SYSCTRL:  d_nxt.sc = `PIS_ZERO_WORD;
                PIS_SRC_ANALOGUE: d_nxt.ap = `PIS_ZERO_WORD;
                PIS_SRC_TIMER0:   d_nxt.tm[0] = 2'b00;
                PIS_SRC_TIMER1:   d_nxt.tm[1] = 2'b00;
                PIS_SRC_TIMER2:   d_nxt.tm[2] = 2'b00;
                PIS_SRC_TIMER3:   d_nxt.tm[3] = 2'b00;
                PIS_SRC_TIMER4:   d_nxt.tm[4] = 2'b00;
                PIS_SRC_TICK:     d_nxt.tick = 1'b0;
                PIS_SRC_INFRARED: d_nxt.ir = 1'b0;
                PIS_SRC_TWO_WIRE: begin
                    d_nxt.sm = `PIS_ZERO_WORD;
                    d_nxt.ss = `PIS_ZERO_WORD;
                end
                // Codes never presented have no sticky bits to clear
                default: d_nxt.st = PIS_ST_IDLE;
            endcase
        end

        // Sticky causes: new events ORed in after any clear
        d_nxt.sc = d_nxt.sc | sc_ev;
        d_nxt.ap = d_nxt.ap | ap_ev;
        for (int i = 0; i < NUM_TIMERS; i++) begin
            d_nxt.tm[i][`PIS_TM_RISE] = d_nxt.tm[i][`PIS_TM_RISE] | t_rise[i];
            d_nxt.tm[i][`PIS_TM_PER]  = d_nxt.tm[i][`PIS_TM_PER] | t_fall[i];
        end
        d_nxt.tick = d_nxt.tick | tick_event;
        d_nxt.ir = d_nxt.ir | infrared_send_done;
        d_nxt.sm = d_nxt.sm | sm_ev;
        d_nxt.ss = d_nxt.ss | ss_ev;

        // Fixed priority; one source is frozen while presented so the processor
        // sees no word change under it, except the two-wire live bits 1 and 6.
        if (q_r.st == PIS_ST_IDLE) begin
            d_nxt.code = pick_code;
            d_nxt.word = pick_word;
            if (pick_word != `PIS_ZERO_WORD) begin
                d_nxt.st = PIS_ST_REPORT;
                d_nxt.irq = 1'b1;
            end
        end

        // Transfer-active and bus-active are live levels in the word; the
        // slave's tx-taken cause shares bit 1, so it is ORed, not replaced.
        if (d_nxt.code == PIS_SRC_TWO_WIRE && d_nxt.st == PIS_ST_REPORT) begin
            d_nxt.word[`PIS_SM_TIP]  = two_wire_transfer_active
                                     | q_r.ss[`PIS_SS_TAKEN];
            d_nxt.word[`PIS_SM_BUSY] = d_nxt.busy;
        end
    end

    // Priority pick of the next source; timers go lowest index first,
    // hence the downward loop in which the last match wins.
    always_comb begin
        pick_code = q_r.code;
        pick_word = `PIS_ZERO_WORD;
        if (q_r.sc != `PIS_ZERO_WORD) begin
            pick_code = PIS_SRC_SYSCTRL;
            pick_word = q_r.sc;
        end else if (q_r.ap != `PIS_ZERO_WORD) begin
            pick_code = PIS_SRC_ANALOGUE;
            pick_word = q_r.ap;
        end else if (q_r.tm != '0) begin
            for (int i = NUM_TIMERS - 1; i >= 0; i--) begin
                if (q_r.tm[i] != 2'b00) begin
                    pick_code = pis_src_t'(PIS_SRC_TIMER0 + i);
                    pick_word = {30'h0, q_r.tm[i]};
                end
            end
        end else if (q_r.tick) begin
            // Tick and infrared words are fixed at bit 0
            pick_code = PIS_SRC_TICK;
            pick_word[`PIS_TICK_BIT] = 1'b1;
        end else if (q_r.sm != `PIS_ZERO_WORD
                     || q_r.ss != `PIS_ZERO_WORD) begin
            pick_code = PIS_SRC_TWO_WIRE;
            pick_word = q_r.sm | q_r.ss;
        end else if (q_r.ir) begin
            pick_code = PIS_SRC_INFRARED;
            pick_word[`PIS_IR_BIT] = 1'b1;
        end
    end

    // State register for the whole block except the timer output delay
    always_ff @(posedge mclk) begin
        if (rst) begin
            q_r <= '0;
        end else begin
            q_r <= d_nxt;
        end
    end

    // Every output is a field of the state register
    assign irq_valid              = q_r.irq;
    assign source_peripheral_code = q_r.code;
    assign cause_word             = q_r.word;
    assign two_wire_bus_active    = q_r.busy;

endmodule

// ===== dv/pis_chk.sv
// Checker: timing and encoding relations at the status block's ports.
// Assumes it is bound to pis_core and sees nothing but its ports.
`timescale 1ns/1ps
`include "pis_defines.svh"

module pis_chk (
    input wire logic                   mclk,
    input wire logic                   rst,
    input wire logic                   clock_switch_event,
    input wire logic                   two_wire_start_seen,
    input wire logic                   two_wire_stop_seen,
    input wire logic                   ack,
    input wire logic                   irq_valid,
    input wire logic [`PIS_CODE_W-1:0] source_peripheral_code,
    input wire logic [`PIS_WORD_W-1:0] cause_word,
    input wire logic                   two_wire_bus_active
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire logic [`PIS_CODE_W-1:0] c = source_peripheral_code;
    wire logic [`PIS_WORD_W-1:0] w = cause_word;

    a_ack_drop: assert property (
        irq_valid && ack |=> !irq_valid) else $error("valid held after ack");
    a_word_stands: assert property (
        irq_valid && !ack && c != 5'h0a |=> irq_valid && $stable(c)
        && $stable(w)) else $error("presented source changed early");
    a_code_legal: assert property (
        irq_valid |-> c inside {5'h00, 5'h01, [5'h04:5'h08], 5'h09, 5'h0a,
        5'h0e}) else $error("source code not produced by block");
    a_tick_word: assert property (
        irq_valid && c == 5'h09 |-> w == 32'h0000_0001)
        else $error("tick word not one");
    a_ir_word: assert property (
        irq_valid && c == 5'h0e |-> w == 32'h0000_0001)
        else $error("infrared word not one");
    a_timer_bits: assert property (
        irq_valid && c inside {[5'h04:5'h08]} |-> w[31:2] == 30'h0000_0000)
        else $error("timer word has stray bits");
    a_dio_gap: assert property (
        irq_valid && c == 5'h00 |-> !w[21]) else $error("system bit 21 set");
    a_sys_fast: assert property (
        clock_switch_event && !irq_valid && !$past(irq_valid) |-> ##2
        (irq_valid && c == 5'h00 && w[31])) else $error("clock switch late");
    a_bus_start: assert property (
        two_wire_start_seen |=> two_wire_bus_active)
        else $error("bus active not set by start");
    a_bus_stop: assert property (
        two_wire_stop_seen && !two_wire_start_seen |=> !two_wire_bus_active)
        else $error("bus active not cleared by stop");
    a_bus_hold: assert property (
        !two_wire_start_seen && !two_wire_stop_seen |=>
        $stable(two_wire_bus_active)) else $error("bus active moved alone");
endmodule

bind pis_core pis_chk u_chk (.mclk, .rst, .clock_switch_event,
    .two_wire_start_seen, .two_wire_stop_seen, .ack, .irq_valid,
    .source_peripheral_code, .cause_word, .two_wire_bus_active);

// ===== dv/pis_cpu_model.sv
// Processor side: acknowledges each presented source once.
// Assumes the bench raises hold while it inspects the presented word.
`timescale 1ns/1ps

module pis_cpu_model (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic irq_valid,
    input  wire logic hold,
    output logic      ack
);
    // Never two acks in a row, so one ack cannot clear the next source
    always_ff @(posedge mclk) begin
        if (rst) begin
            ack <= 1'b0;
        end else begin
            ack <= irq_valid && !ack && !hold;
        end
    end
endmodule

// ===== dv/test_peripheral_interrupt_status.sv
// Bench: pulses peripheral events and judges code and cause word.
// Assumes pis_core, its checker and the processor model are compiled.
`timescale 1ns/1ps

module test_peripheral_interrupt_status;
    import pis_pkg::*;
    logic        mclk = 1'b0;
    logic        rst  = 1'b1;
    logic [31:0] ev   = '0;
    logic [4:0]  ap = '0, ss = '0, tmo = '0, ren = '0, pen = '0;
    logic [5:0]  tw   = '0;
    logic        tick = 1'b0, ir = 1'b0, mode = 1'b0, twa = 1'b0;
    logic        hold = 1'b1;
    wire logic        ack, vld, bus;
    wire logic [4:0]  code;
    wire logic [31:0] word;
    int          err_count = 0;
    int          check_count = 0;

    always #2.5 mclk = ~mclk;

    pis_core u_dut (.mclk(mclk), .rst(rst), .clock_switch_event(ev[31]),
        .random_value_ready(ev[30]), .comparator_one_event(ev[29]),
        .comparator_zero_event(ev[28]), .wake_timer_one_event(ev[27]),
        .wake_timer_zero_event(ev[26]), .brownout_entered(ev[25]),
        .brownout_exited(ev[24]), .pulse_count_one_match(ev[23]),
        .pulse_count_zero_match(ev[22]), .dio_event(ev[20:0]),
        .adc_dma_overflow(ap[4]), .adc_dma_full(ap[3]),
        .adc_dma_half_full(ap[2]), .adc_accumulate_mode(mode),
        .adc_accumulate_done(ap[1]), .adc_sample_done(ap[0]),
        .timer_output(tmo), .timer_rise_irq_en(ren),
        .timer_period_irq_en(pen), .tick_event(tick),
        .infrared_send_done(ir), .two_wire_no_ack(tw[3]),
        .two_wire_start_seen(tw[5]), .two_wire_stop_seen(tw[4]),
        .two_wire_arb_lost(tw[2]), .two_wire_bad_command(tw[1]),
        .two_wire_transfer_active(twa), .two_wire_byte_done(tw[0]),
        .two_wire_slave_protocol_error(ss[4]),
        .two_wire_slave_burst_end(ss[3]), .two_wire_slave_rx_waiting(ss[2]),
        .two_wire_slave_tx_taken(ss[1]), .two_wire_slave_tx_needed(ss[0]),
        .ack(ack), .irq_valid(vld), .source_peripheral_code(code),
        .cause_word(word), .two_wire_bus_active(bus));

    pis_cpu_model u_cpu (.mclk(mclk), .rst(rst), .irq_valid(vld),
        .hold(hold), .ack(ack));

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wait_vld(logic v);
        int n;
        n = 0;
        while (vld !== v) begin
            @(negedge mclk);
            n++;
            if (n > 20) begin
                err_count++;
                $display("CHECK FAILED irq_valid wait expected %b seen %b",
                         v, vld);
                close_out();
            end
        end
    endtask

    // Holds the source until judged, then lets the processor acknowledge
    task automatic see(logic [4:0] c, logic [31:0] w);
        wait_vld(1'b1);
        chk("code", c, code);
        chk("word", w, word);
        hold = 1'b0;
        wait_vld(1'b0);
        @(negedge mclk);
        hold = 1'b1;
    endtask

    task automatic quiet();
        repeat (6) @(negedge mclk);
        chk("no irq", 1'b0, vld);
    endtask

    task automatic t_sys();
        for (int i = 0; i < 32; i++) begin
            if (i != 21) begin
                ev = 32'h0000_0001 << i;
                @(negedge mclk);
                ev = '0;
                see(5'h00, 32'h0000_0001 << i);
            end
        end
        ev = 32'hffdf_ffff;
        @(negedge mclk);
        ev = '0;
        see(5'h00, 32'hffdf_ffff);
        $display("t_sys done");
    endtask

    task automatic t_adc();
        ap = 5'h1f;
        @(negedge mclk);
        ap = '0;
        see(5'h01, 32'h0000_001d);
        mode = 1'b1;
        ap = 5'h03;
        @(negedge mclk);
        ap = '0;
        see(5'h01, 32'h0000_0003);
        mode = 1'b0;
        $display("t_adc done");
    endtask

    // Each edge is tried with its enable on and off
    task automatic t_timer();
        for (int i = 0; i < 5; i++) begin
            ren[i] = 1'b1;
            tmo[i] = 1'b1;
            see(5'(4 + i), 32'h0000_0002);
            tmo[i] = 1'b0;
            quiet();
            ren[i] = 1'b0;
            pen[i] = 1'b1;
            tmo[i] = 1'b1;
            quiet();
            tmo[i] = 1'b0;
            see(5'(4 + i), 32'h0000_0001);
            pen[i] = 1'b0;
        end
        $display("t_timer done");
    endtask

    task automatic t_prio();
        ev = 32'h0000_0001;
        tick = 1'b1;
        ir = 1'b1;
        @(negedge mclk);
        ev = '0;
        tick = 1'b0;
        ir = 1'b0;
        see(5'h00, 32'h0000_0001);
        see(5'h09, 32'h0000_0001);
        see(5'h0e, 32'h0000_0001);
        $display("t_prio done");
    endtask

    task automatic pulse_tw(logic [5:0] m, logic [4:0] s);
        tw = m;
        ss = s;
        @(negedge mclk);
        tw = '0;
        ss = '0;
    endtask

    task automatic t_wire();
        twa = 1'b1;
        pulse_tw(6'h2a, 5'h00);
        see(5'h0a, 32'h0000_00c6);
        chk("bus active", 1'b1, bus);
        twa = 1'b0;
        pulse_tw(6'h04, 5'h00);
        see(5'h0a, 32'h0000_0061);
        pulse_tw(6'h11, 5'h00);
        see(5'h0a, 32'h0000_0001);
        chk("bus idle", 1'b0, bus);
        pulse_tw(6'h00, 5'h1f);
        see(5'h0a, 32'h0000_001f);
        $display("t_wire done");
    endtask

    // A cause pulsed in the ack cycle survives the clear of its source
    task automatic t_race();
        ev = 32'h0000_0002;
        @(negedge mclk);
        ev = '0;
        wait_vld(1'b1);
        chk("race first word", 32'h0000_0002, word);
        hold = 1'b0;
        @(negedge mclk);
        ev = 32'h0000_0004;
        @(negedge mclk);
        ev = '0;
        hold = 1'b1;
        chk("race ack taken", 1'b0, vld);
        see(5'h00, 32'h0000_0004);
        $display("t_race done");
    endtask

    initial begin
        repeat (12) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        t_sys();
        t_adc();
        t_timer();
        t_prio();
        t_wire();
        t_race();
        close_out();
    end
endmodule
